/* File: rtl/ssp_pkg.sv */
// Purpose: Shared constants and carrier types for the synchronous serial port
// Assumes: AXI4-Lite register access, 8-bit registers in the low byte of each word
// Notes: Byte addresses are word aligned; twelve registers in the frame

package ssp_pkg;

    // Register byte addresses inside the frame
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHARLEN = 8'h04;
    localparam logic [7:0] ADDR_BAUD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TXLO = 8'h10;
    localparam logic [7:0] ADDR_TXHI = 8'h14;
    localparam logic [7:0] ADDR_RXLO = 8'h18;
    localparam logic [7:0] ADDR_RXHI = 8'h1c;
    localparam logic [7:0] ADDR_FIFOTX = 8'h20;
    localparam logic [7:0] ADDR_FIFORX = 8'h24;
    localparam logic [7:0] ADDR_INTEN = 8'h28;
    localparam logic [7:0] ADDR_GPIO = 8'h2c;
    localparam logic [5:0] REG_COUNT = 6'h0c;

    // Control register fields
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_TALK = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_PHASE = 3;
    localparam int CTRL_ENABLE = 4;

    // Status register fields
    localparam int ST_RX_READY = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_TX_FULL = 2;
    localparam int ST_BUSY = 3;

    // Interrupt enable fields
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;

    // Reset values
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [3:0] CHARLEN_RESET = 4'h7;
    localparam logic [6:0] BAUD_RESET = 7'h7f;
    localparam logic FIFO_EN_RESET = 1'b0;
    localparam logic [1:0] INTEN_RESET = 2'h0;
    localparam logic [3:0] GPIO_OUT_RESET = 4'h0;
    localparam logic [3:0] GPIO_DIR_RESET = 4'h0;

    // Bit-rate divider: half period is max(baud, BAUD_MIN) + 1 cycles
    localparam logic [6:0] BAUD_MIN = 7'h03;

    // Queue depths: full FIFO or single buffer when bypassed
    localparam int FIFO_ENTRIES = 16;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] SINGLE_DEPTH = 5'h01;

    // Pin indices on the four-wire link
    localparam int PIN_SCLK = 0;
    localparam int PIN_SIMO = 1;
    localparam int PIN_SOMI = 2;
    localparam int PIN_STE = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_SHIFT = 2'b10
    } ssp_eng_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } ssp_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssp_axi_rsp_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } ssp_pin_drv_t;

endpackage

/* File: rtl/ssp_port.sv */
// Purpose: Synchronous serial port, master or slave, with 16-entry FIFOs and AXI4-Lite registers
// Assumes: sys_clk at 10 MHz, synchronous active-high reset, pins sampled through two flip-flops
// Notes: Pin index 0 clock, 1 slave-in/master-out, 2 slave-out/master-in, 3 slave transmit enable
//
// Function
// - Words of one to sixteen bits shift in and out together.
// - Master drives the serial clock and starts transfers; slave follows external clock.
// - Master bit rate selectable among 125 divider settings of the module clock.
// - Clock idle high, no phase: drive on falling edge, sample on rising.
// - Clock idle high, phase: drive half cycle early, sample on falling edge.
// - Clock idle low, no phase: drive on rising edge, sample on falling.
// - Clock idle low, phase: drive half cycle early, sample on rising edge.
// - Control bit 3 selects phase delay, moving both directions half a cycle earlier.
// - Data leaves on one clock edge and is captured on the opposite edge.
// - Full duplex; software can disable transmit while reception continues.
// - Sixteen-entry transmit and receive FIFOs sit between CPU and shift register.
// - FIFO enable bit selects FIFOs or single buffering for both directions.
// - Register reads return contents in low byte, zeros above.
// - Writes to the upper byte are ignored.
// - Twelve control and status registers in one frame.
// - Pollable flags and transmit/receive interrupt requests.
// - Slave drives its output only while selected by the transmit-enable line.
// - With the port disabled the four pins serve as general-purpose I/O.

`timescale 1ns/1ns

module ssp_port
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ssp_axi_req_t axiReq,
    output ssp_axi_rsp_t axiRsp,
    input wire logic [3:0] pinIn,
    output ssp_pin_drv_t pinDrv,
    output logic rxIntReq,
    output logic txIntReq
);

    logic [4:0] ctrlReg;
    logic [3:0] charLenReg;
    logic [6:0] baudReg;
    logic fifoEnReg;
    logic [1:0] intEnReg;
    logic [3:0] gpioOutReg;
    logic [3:0] gpioDirReg;
    logic [7:0] txHiReg;
    logic [7:0] rxHiReg;
    logic overrunReg;

    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic sclkPrev;

    logic awHeld;
    logic wHeld;
    logic [7:0] awAddrReg;
    logic [7:0] wDataReg;
    logic wLaneReg;
    logic [7:0] readByte;
    logic readMapped;

    logic [15:0] txMem [FIFO_ENTRIES];
    logic [15:0] rxMem [FIFO_ENTRIES];
    logic [3:0] txWr;
    logic [3:0] txRd;
    logic [4:0] txCnt;
    logic [3:0] rxWr;
    logic [3:0] rxRd;
    logic [4:0] rxCnt;

    ssp_eng_t engState;
    logic [4:0] edgeCnt;
    logic [15:0] txShift;
    logic [15:0] rxShift;
    logic doutReg;
    logic sclkOutReg;
    logic [6:0] divCnt;

    // Control decode
    logic enabled;
    logic isMaster;
    logic talk;
    logic pol;
    logic phase;
    assign enabled = ctrlReg[CTRL_ENABLE];
    assign isMaster = ctrlReg[CTRL_MASTER];
    assign talk = ctrlReg[CTRL_TALK];
    assign pol = ctrlReg[CTRL_POL];
    assign phase = ctrlReg[CTRL_PHASE];

    logic slaveSelected;
    assign slaveSelected = enabled & ~isMaster & ~pinSync[PIN_STE];

    // Bus handshake decode
    logic wrFire;
    logic wrEn;
    logic rdFire;
    logic awMapped;
    assign wrFire = awHeld & wHeld & ~axiRsp.bvalid;
    assign wrEn = wrFire & wLaneReg;
    assign rdFire = axiReq.arvalid & axiRsp.arready;
    assign awMapped = (awAddrReg[1:0] == 2'h0) && (awAddrReg[7:2] < REG_COUNT);

    // Queue levels; bypass shrinks both queues to one entry
    logic [4:0] fifoLimit;
    logic txFull;
    logic rxFull;
    logic txAvail;
    logic rxAvail;
    assign fifoLimit = fifoEnReg ? FIFO_DEPTH : SINGLE_DEPTH;
    assign txFull = txCnt >= fifoLimit;
    assign rxFull = rxCnt >= fifoLimit;
    assign txAvail = txCnt != 5'h00;
    assign rxAvail = rxCnt != 5'h00;

    // Shift engine events
    logic [6:0] halfDiv;
    logic divTick;
    logic ev;
    logic isLead;
    logic lastEdge;
    logic sampleEv;
    logic driveEv;
    logic din;
    logic [15:0] rxNext;
    logic [15:0] rxWord;
    logic startMaster;
    logic startSlave;
    logic txPop;
    logic [15:0] loadWord;
    logic rxPush;
    logic rxPop;
    logic txPush;

    assign halfDiv = (baudReg < BAUD_MIN) ? BAUD_MIN : baudReg;
    assign divTick = (engState == ENG_SHIFT) && isMaster && (divCnt >= halfDiv);
    // Slave counts edges only while selected; clock ignored otherwise
    assign ev = isMaster ? divTick
        : (engState == ENG_SHIFT) & slaveSelected & (pinSync[PIN_SCLK] ^ sclkPrev);
    assign isLead = ~edgeCnt[0];
    assign lastEdge = edgeCnt == {charLenReg, 1'b1};
    // Phase moves both directions half a cycle earlier
    assign sampleEv = ev & (phase ? isLead : ~isLead);
    assign driveEv = ev & (phase ? (~isLead & ~lastEdge) : isLead);
    assign din = isMaster ? pinSync[PIN_SOMI] : pinSync[PIN_SIMO];
    assign rxNext = sampleEv ? {rxShift[14:0], din} : rxShift;
    assign rxWord = rxNext & (16'hffff >> (4'hf - charLenReg));

    assign startMaster = enabled & isMaster & (engState == ENG_IDLE) & txAvail;
    assign startSlave = slaveSelected & (engState == ENG_IDLE);
    assign txPop = (startMaster | startSlave) & txAvail;
    // Slave with an empty queue answers with zeros
    assign loadWord = (txAvail ? txMem[txRd] : 16'h0000) << (4'hf - charLenReg);
    assign rxPush = ev & lastEdge;
    assign rxPop = rdFire & (axiReq.araddr == ADDR_RXLO) & rxAvail;
    assign txPush = wrEn & (awAddrReg == ADDR_TXLO) & ~txFull;

    // Two flip-flops ahead of any logic on every pin input
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
            sclkPrev <= 1'b0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            sclkPrev <= pinSync[PIN_SCLK];
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            axiRsp.awready <= 1'b1;
            axiRsp.wready <= 1'b1;
            axiRsp.bvalid <= 1'b0;
            axiRsp.bresp <= RESP_OKAY;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 8'h00;
            wDataReg <= 8'h00;
            wLaneReg <= 1'b0;
        end else begin
            if (axiReq.awvalid & axiRsp.awready) begin
                awAddrReg <= axiReq.awaddr;
                awHeld <= 1'b1;
                axiRsp.awready <= 1'b0;
            end
            if (axiReq.wvalid & axiRsp.wready) begin
                wDataReg <= axiReq.wdata[7:0];
                wLaneReg <= axiReq.wstrb[0];
                wHeld <= 1'b1;
                axiRsp.wready <= 1'b0;
            end
            if (wrFire) begin
                axiRsp.bvalid <= 1'b1;
                axiRsp.bresp <= awMapped ? RESP_OKAY : RESP_SLVERR;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
            if (axiRsp.bvalid & axiReq.bready) begin
                axiRsp.bvalid <= 1'b0;
                axiRsp.awready <= 1'b1;
                axiRsp.wready <= 1'b1;
            end
        end
    end

    // Read data selection
    always_comb begin
        readByte = 8'h00;
        readMapped = 1'b1;
        unique case (axiReq.araddr)
            ADDR_CTRL: readByte = {3'h0, ctrlReg};
            ADDR_CHARLEN: readByte = {4'h0, charLenReg};
            ADDR_BAUD: readByte = {1'b0, baudReg};
            ADDR_STATUS: begin
                readByte[ST_RX_READY] = rxAvail;
                readByte[ST_OVERRUN] = overrunReg;
                readByte[ST_TX_FULL] = txFull;
                readByte[ST_BUSY] = engState == ENG_SHIFT;
            end
            ADDR_TXLO: readByte = 8'h00;
            ADDR_TXHI: readByte = txHiReg;
            ADDR_RXLO: readByte = rxAvail ? rxMem[rxRd][7:0] : 8'h00;
            ADDR_RXHI: readByte = rxHiReg;
            ADDR_FIFOTX: readByte = {2'h0, txCnt, fifoEnReg};
            ADDR_FIFORX: readByte = {3'h0, rxCnt};
            ADDR_INTEN: readByte = {pinSync, 2'h0, intEnReg};
            ADDR_GPIO: readByte = {gpioDirReg, gpioOutReg};
            default: readMapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            axiRsp.arready <= 1'b1;
            axiRsp.rvalid <= 1'b0;
            axiRsp.rdata <= 32'h00000000;
            axiRsp.rresp <= RESP_OKAY;
        end else begin
            if (rdFire) begin
                axiRsp.rvalid <= 1'b1;
                axiRsp.rdata <= {24'h000000, readByte};
                axiRsp.rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
                axiRsp.arready <= 1'b0;
            end
            if (axiRsp.rvalid & axiReq.rready) begin
                axiRsp.rvalid <= 1'b0;
                axiRsp.arready <= 1'b1;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrlReg <= CTRL_RESET;
            charLenReg <= CHARLEN_RESET;
            baudReg <= BAUD_RESET;
            fifoEnReg <= FIFO_EN_RESET;
            intEnReg <= INTEN_RESET;
            gpioOutReg <= GPIO_OUT_RESET;
            gpioDirReg <= GPIO_DIR_RESET;
            txHiReg <= 8'h00;
        end else if (wrEn) begin
            unique case (awAddrReg)
                ADDR_CTRL: ctrlReg <= wDataReg[4:0];
                ADDR_CHARLEN: charLenReg <= wDataReg[3:0];
                ADDR_BAUD: baudReg <= wDataReg[6:0];
                ADDR_TXHI: txHiReg <= wDataReg;
                ADDR_FIFOTX: fifoEnReg <= wDataReg[0];
                ADDR_INTEN: intEnReg <= wDataReg[1:0];
                ADDR_GPIO: begin
                    gpioOutReg <= wDataReg[3:0];
                    gpioDirReg <= wDataReg[7:4];
                end
                default: ;
            endcase
        end
    end

    // Overrun: a new word arriving in the clearing cycle still sets it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overrunReg <= 1'b0;
        end else if (rxPush & rxFull) begin
            overrunReg <= 1'b1;
        end else if (wrEn && awAddrReg == ADDR_STATUS && wDataReg[ST_OVERRUN]) begin
            overrunReg <= 1'b0;
        end
    end

    // Transmit queue; a write to the low byte commits the staged high byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txWr <= 4'h0;
            txRd <= 4'h0;
            txCnt <= 5'h00;
        end else begin
            if (txPush) begin
                txMem[txWr] <= {txHiReg, wDataReg};
                txWr <= txWr + 4'h1;
            end
            if (txPop) begin
                txRd <= txRd + 4'h1;
            end
            unique case ({txPush, txPop})
                2'b10: txCnt <= txCnt + 5'h01;
                2'b01: txCnt <= txCnt - 5'h01;
                default: ;
            endcase
        end
    end

    // Receive queue; reading the low byte pops and holds the high byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxWr <= 4'h0;
            rxRd <= 4'h0;
            rxCnt <= 5'h00;
            rxHiReg <= 8'h00;
        end else begin
            if (rxPush & ~rxFull) begin
                rxMem[rxWr] <= rxWord;
                rxWr <= rxWr + 4'h1;
            end
            if (rxPop) begin
                rxHiReg <= rxMem[rxRd][15:8];
                rxRd <= rxRd + 4'h1;
            end
            unique case ({rxPush & ~rxFull, rxPop})
                2'b10: rxCnt <= rxCnt + 5'h01;
                2'b01: rxCnt <= rxCnt - 5'h01;
                default: ;
            endcase
        end
    end

    // Half-period divider; runs only while a master transfer is active
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            divCnt <= 7'h00;
        end else if (engState != ENG_SHIFT || !isMaster || divTick) begin
            divCnt <= 7'h00;
        end else begin
            divCnt <= divCnt + 7'h01;
        end
    end

    // Shift engine shared by master and slave
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            engState <= ENG_IDLE;
            edgeCnt <= 5'h00;
            txShift <= 16'h0000;
            rxShift <= 16'h0000;
            doutReg <= 1'b0;
            sclkOutReg <= 1'b0;
        end else if (!enabled) begin
            engState <= ENG_IDLE;
            edgeCnt <= 5'h00;
            sclkOutReg <= pol;
        end else begin
            unique case (engState)
                ENG_IDLE: begin
                    sclkOutReg <= pol;
                    edgeCnt <= 5'h00;
                    if (startMaster | startSlave) begin
                        engState <= ENG_SHIFT;
                        if (phase) begin
                            // First bit leads the first clock edge by half a cycle
                            doutReg <= loadWord[15];
                            txShift <= {loadWord[14:0], 1'b0};
                        end else begin
                            txShift <= loadWord;
                        end
                    end
                end
                ENG_SHIFT: begin
                    if (!isMaster && !slaveSelected) begin
                        // Deselect mid-word discards the partial word
                        engState <= ENG_IDLE;
                    end else if (ev) begin
                        edgeCnt <= edgeCnt + 5'h01;
                        if (isMaster) begin
                            sclkOutReg <= ~sclkOutReg;
                        end
                        if (sampleEv) begin
                            rxShift <= rxNext;
                        end
                        if (driveEv) begin
                            doutReg <= txShift[15];
                            txShift <= {txShift[14:0], 1'b0};
                        end
                        if (lastEdge) begin
                            engState <= ENG_IDLE;
                        end
                    end
                end
                default: engState <= ENG_IDLE;
            endcase
        end
    end

    // Pin drivers, registered; disabled port hands pins to GPIO
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinDrv.out <= 4'h0;
            pinDrv.oe <= 4'h0;
        end else if (!enabled) begin
            pinDrv.out <= gpioOutReg;
            pinDrv.oe <= gpioDirReg;
        end else if (isMaster) begin
            pinDrv.out[PIN_SCLK] <= sclkOutReg;
            pinDrv.oe[PIN_SCLK] <= 1'b1;
            pinDrv.out[PIN_SIMO] <= doutReg;
            pinDrv.oe[PIN_SIMO] <= talk;
            pinDrv.out[PIN_SOMI] <= 1'b0;
            pinDrv.oe[PIN_SOMI] <= 1'b0;
            pinDrv.out[PIN_STE] <= engState != ENG_SHIFT;
            pinDrv.oe[PIN_STE] <= 1'b1;
        end else begin
            pinDrv.out <= 4'h0;
            pinDrv.oe <= 4'h0;
            pinDrv.out[PIN_SOMI] <= doutReg;
            pinDrv.oe[PIN_SOMI] <= talk & slaveSelected;
        end
    end

    // Level interrupt requests for the CPU
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxIntReq <= 1'b0;
            txIntReq <= 1'b0;
        end else begin
            rxIntReq <= intEnReg[IE_RX] & (rxAvail | overrunReg);
            txIntReq <= intEnReg[IE_TX] & ~txFull;
        end
    end

endmodule

/* File: sim/ssp_port_asserts.sv */
// Purpose: Bus and pin timing checks on the serial port top
// Assumes: Single clock domain, reset synchronous active high
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ns
module ssp_port_asserts
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ssp_axi_req_t axiReq,
    input wire ssp_axi_rsp_t axiRsp,
    input wire logic [3:0] pinIn,
    input wire ssp_pin_drv_t pinDrv,
    input wire logic rxIntReq,
    input wire logic txIntReq
);
    default clocking @(posedge sys_clk); endclocking
    property p_rd_upper;
        disable iff (sys_rst) axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
    property p_rd_busy;
        disable iff (sys_rst) axiRsp.rvalid |-> !axiRsp.arready;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read address taken during answer");
    property p_wr_busy;
        disable iff (sys_rst) axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken during answer");
    property p_ar_take;
        disable iff (sys_rst) axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
    endproperty
    a_ar_take: assert property (p_ar_take) else $error("read answer late");
    property p_w_take;
        disable iff (sys_rst)
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##[1:2] axiRsp.bvalid;
    endproperty
    a_w_take: assert property (p_w_take) else $error("write answer late");
    property p_resp;
        disable iff (sys_rst) axiRsp.rvalid |-> axiRsp.rresp == RESP_OKAY || axiRsp.rresp == RESP_SLVERR;
    endproperty
    a_resp: assert property (p_resp) else $error("bad read response code");
    property p_rst;
        $fell(sys_rst) |-> axiRsp.awready && !axiRsp.bvalid && !axiRsp.rvalid && pinDrv == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("pins or bus not idle after reset");
    // Fastest divider gives four cycles per half period
    property p_sclk;
        disable iff (sys_rst)
        pinDrv.oe[PIN_SCLK] && $changed(pinDrv.out[PIN_SCLK]) |=> $stable(pinDrv.out[PIN_SCLK]) [*3];
    endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock half period too short");
    c_rd: cover property (axiRsp.rvalid && axiReq.rready);
    c_wr: cover property (axiRsp.bvalid && axiReq.bready);
    c_sclk: cover property (pinDrv.oe[PIN_SCLK] && $changed(pinDrv.out[PIN_SCLK]));
endmodule
bind ssp_port ssp_port_asserts chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .pinIn(pinIn), .pinDrv(pinDrv), .rxIntReq(rxIntReq), .txIntReq(txIntReq));

/* File: sim/ssp_peer.sv */
// Purpose: External slave peripheral on the four-wire link
// Assumes: Select active low, MSB first, mode given by the bench
// Notes: Released output shows the inverse of its last bit
`timescale 1ns/1ns
module ssp_peer (
    input wire logic serialClk,
    input wire logic dataIn,
    input wire logic selectN,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [15:0] txWord,
    input wire logic [4:0] bitLen,
    output logic dataOut,
    output logic [15:0] rxWord
);
    logic [15:0] shiftOut;
    logic selected;
    // Select seen one step late so a clock edge that lands with deselect still counts
    always @(selectN) selected <= !selectN;
    initial dataOut = 1'b0;
    always @(negedge selectN) begin
        rxWord = 16'h0;
        shiftOut = txWord << (16 - bitLen);
        if (cpha) begin
            dataOut = shiftOut[15];
            shiftOut = shiftOut << 1;
        end
    end
    always @(posedge selectN) dataOut = ~dataOut;
    always @(serialClk) begin
        if (selected && ((serialClk !== cpol) ^ cpha)) begin
            dataOut = shiftOut[15];
            shiftOut = shiftOut << 1;
        end else if (selected) begin
            rxWord = {rxWord[14:0], dataIn};
        end
    end
endmodule

/* File: sim/test_ssp_port.sv */
// Purpose: Self-checking bench for the serial port
// Assumes: 10 MHz clock, registers reached over AXI4-Lite
// Notes: Master mode traffic against a slave model, then one slave-mode word with the bench as master
`timescale 1ns/1ns
module test_ssp_port
    import ssp_pkg::*;
;
    logic sys_clk, sys_rst, rxIntReq, txIntReq, mosiFloat, cpol, cpha, peerOut, bSel;
    ssp_axi_req_t axiReq;
    ssp_axi_rsp_t axiRsp;
    ssp_pin_drv_t pinDrv;
    logic [3:0] pinIn;
    logic [15:0] peerTx, peerRx;
    logic [4:0] peerLen;
    logic [1:0] wResp;
    int errCount, cmpCount;
    // Select pulled up unless the bench acts as master; other lines fall back to the idle parties
    assign pinIn = {pinDrv.oe[3] ? pinDrv.out[3] : bSel, pinDrv.oe[2] ? pinDrv.out[2] : peerOut,
        pinDrv.oe[1] ? pinDrv.out[1] : mosiFloat, pinDrv.oe[0] ? pinDrv.out[0] : cpol};
    ssp_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
        .pinIn(pinIn), .pinDrv(pinDrv), .rxIntReq(rxIntReq), .txIntReq(txIntReq));
    ssp_peer peer_u (.serialClk(pinIn[0]), .dataIn(pinIn[1]), .selectN(pinIn[3]), .cpol(cpol),
        .cpha(cpha), .txWord(peerTx), .bitLen(peerLen), .dataOut(peerOut), .rxWord(peerRx));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (bSel) mosiFloat <= ~mosiFloat;
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1);
        wResp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1);
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask
    // Mode bit 1 is phase, bit 0 polarity
    task automatic xfer(input logic [1:0] md, input logic talk, input int n);
        logic [15:0] w, pw, m;
        logic [31:0] d;
        logic [1:0] r;
        w = 16'($urandom);
        pw = 16'($urandom);
        m = 16'((17'h1 << n) - 17'h1);
        peerTx <= pw;
        peerLen <= 5'(n);
        cpol <= md[0];
        cpha <= md[1];
        wr(ADDR_FIFOTX, {31'h0, 1'($urandom)});
        wr(ADDR_CHARLEN, 32'(n - 1));
        wr(ADDR_BAUD, 32'h0);
        wr(ADDR_CTRL, {27'h0, 1'b1, md[1], md[0], talk, 1'b1});
        wr(ADDR_TXHI, {24'h0, w[15:8]});
        wr(ADDR_TXLO, {24'h0, w[7:0]});
        do rd(ADDR_STATUS, d, r); while (d[ST_RX_READY] === 1'b0);
        rd(ADDR_RXLO, d, r);
        chk(d, {24'h0, pw[7:0] & m[7:0]});
        rd(ADDR_RXHI, d, r);
        chk(d, {24'h0, pw[15:8] & m[15:8]});
        if (talk) chk({16'h0, peerRx & m}, {16'h0, w & m});
        else chk({31'h0, pinDrv.oe[PIN_SIMO]}, 32'h0);
    endtask
    // Bench as master, port as slave, idle-low clock without phase, half period six cycles
    task automatic slv(input logic [7:0] w, input logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_CTRL, 32'h0);
        cpol <= 1'b0;
        wr(ADDR_CHARLEN, 32'h7);
        wr(ADDR_TXLO, {24'h0, w});
        wr(ADDR_CTRL, 32'h12);
        bSel <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            repeat (6) @(posedge sys_clk);
            cpol <= 1'b1;
            mosiFloat <= v[b];
            repeat (6) @(posedge sys_clk);
            cpol <= 1'b0;
            chk({31'h0, pinIn[PIN_SOMI]}, {31'h0, w[b]});
        end
        repeat (6) @(posedge sys_clk);
        bSel <= 1'b1;
        rd(ADDR_RXLO, d, r);
        chk(d, {24'h0, v});
    endtask
    initial begin
        #2000000;
        errCount++;
        end_of_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axiReq = '0;
        sys_rst = 1'b1;
        mosiFloat = 1'b0;
        bSel = 1'b1;
        cpol = 1'b0;
        cpha = 1'b0;
        peerTx = 16'h0;
        peerLen = 5'h8;
        errCount = 0;
        cmpCount = 0;
        void'($urandom(32'hbb585607));
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(ADDR_CTRL, d, r);
        chk(d, 32'h0);
        rd(ADDR_CHARLEN, d, r);
        chk(d, 32'h7);
        rd(ADDR_BAUD, d, r);
        chk(d, 32'h7f);
        rd(8'h30, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(ADDR_CHARLEN, 32'hffff_ff03);
        rd(ADDR_CHARLEN, d, r);
        chk(d, 32'h3);
        wr(8'h31, 32'h0);
        chk({30'h0, wResp}, {30'h0, RESP_SLVERR});
        wr(ADDR_GPIO, 32'hf5);
        repeat (4) @(posedge sys_clk);
        chk({24'h0, pinDrv}, 32'h5f);
        rd(ADDR_INTEN, d, r);
        chk(d, 32'h50);
        wr(ADDR_GPIO, 32'h0);
        for (int i = 0; i < 8; i++) begin
            n = (i == 0) ? 1 : (i == 1) ? 16 : 1 + int'($urandom % 16);
            xfer(2'(i), i < 7, n);
        end
        slv(8'($urandom), 8'($urandom));
        wr(ADDR_INTEN, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, rxIntReq, txIntReq}, 32'h1);
        end_of_test();
    end
endmodule
